// [core/vc_cap_params.svh]
`ifndef VC_CAP_PARAMS_SVH
`define VC_CAP_PARAMS_SVH

// ----------------------------------------
// Byte offsets in configuration space
// ----------------------------------------
`define OFS_SERIAL_HIGH          12'h0188
`define OFS_VC_HEADER            12'h0200
`define OFS_CHAN_CAP_ONE         12'h0204
`define OFS_CHAN_CAP_TWO         12'h0208
`define OFS_LOCK_CTRL            12'h03F0

// ----------------------------------------
// Reset and fixed field values
// ----------------------------------------
`define SERIAL_HIGH_RESET        32'h0000_0000
`define CAP_ID_VALUE             16'h0002
`define CAP_VERSION_VALUE        4'h1
`define NEXT_PTR_RESET           12'h000
`define EXTRA_CH_COUNT           3'h0
`define LOW_PRI_CH_COUNT         3'h0
`define ARB_TIME_REF             2'h0
`define ENTRY_SIZE_UPSTREAM      2'h2
`define ENTRY_SIZE_DOWNSTREAM    2'h0
`define CH_ARB_SUPPORT           8'h00
`define CH_ARB_TABLE_OFS         8'h00
`define READ_ZERO                32'h0000_0000

// ----------------------------------------
// Arbitration table entry size codes and entry widths in bits
// ----------------------------------------
`define ENTRY_SIZE_BIT1          2'h0
`define ENTRY_SIZE_BIT2          2'h1
`define ENTRY_SIZE_BIT4          2'h2
`define ENTRY_SIZE_BIT8          2'h3
`define ENTRY_BITS_1             4'h1
`define ENTRY_BITS_2             4'h2
`define ENTRY_BITS_4             4'h4
`define ENTRY_BITS_8             4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CAPABILITY_IDENTIFIER_MSB                15
`define CAPABILITY_IDENTIFIER_LSB                0
`define CAPABILITY_VERSION_MSB               19
`define CAPABILITY_VERSION_LSB               16
`define NEXT_PTR_MSB             31
`define NEXT_PTR_LSB             20
`define EXTRA_CNT_MSB            2
`define EXTRA_CNT_LSB            0
`define CAP1_RSVD_A              3
`define LOWPRI_CNT_MSB           6
`define LOWPRI_CNT_LSB           4
`define CAP1_RSVD_B              7
`define TIME_REF_MSB             9
`define TIME_REF_LSB             8
`define ENTRY_SIZE_MSB           11
`define ENTRY_SIZE_LSB           10
`define CAP1_RSVD_MSB            31
`define CAP1_RSVD_LSB            12
`define ARB_SUP_MSB              7
`define ARB_SUP_LSB              0
`define ARB_SUP_RSVD_LSB         4
`define CAP2_RSVD_MSB            23
`define CAP2_RSVD_LSB            8
`define TABLE_OFS_MSB            31
`define TABLE_OFS_LSB            24
`define LOCK_BIT                 0
`define ROLE_BIT                 1

`endif

// [core/vc_cap_pkg.sv]
package vc_cap_pkg;

  typedef enum logic {
    PHASE_IDLE,
    PHASE_ANSWER
  } bus_phase_t;

  typedef struct packed {
    bus_phase_t  phase;
    logic        unmapped;
    logic [31:0] rdata;
    logic [31:0] serial_high;
    logic [11:0] next_ptr;
    logic        locked;
    logic        upstream;
  } cap_state_t;

endpackage : vc_cap_pkg

// [core/entry_size_decode.sv]
`timescale 1ns/1ns
`include "vc_cap_params.svh"

module entry_size_decode (
  // Encoded size
  input  wire logic [1:0] size_i,
  // Entry width in bits
  output logic      [3:0] bits_o
);

  always_comb begin
    case (size_i)
      `ENTRY_SIZE_BIT1: bits_o = `ENTRY_BITS_1;
      `ENTRY_SIZE_BIT2: bits_o = `ENTRY_BITS_2;
      `ENTRY_SIZE_BIT4: bits_o = `ENTRY_BITS_4;
      `ENTRY_SIZE_BIT8: bits_o = `ENTRY_BITS_8;
      default:          bits_o = `ENTRY_BITS_1;
    endcase
  end

endmodule : entry_size_decode

// [core/vc_capability_registers.sv]
// Register access over Wishbone was decided locally.
`timescale 1ns/1ns
`include "vc_cap_params.svh"

// How it works
// - Upper identifier word writable only while unlocked
// - Header identifier field reads 0x2
// - Header version field reads 0x1
// - Next pointer lock-writable, resets to zero
// - Extra channel count reads zero
// - Low priority channel count reads zero
// - Arbitration time reference reads zero
// - Entry size 0x2 upstream, 0x0 downstream
// - Entry size codes mean 1,2,4,8 bits
// - Channel arbitration support reads zero
// - Support bits: fixed, three round robins, reserved
// - Arbitration table offset reads zero
module vc_capability_registers (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hot_reset_i,
  // Port role strap
  input  wire logic        upstream_port_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [11:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Status
  output logic      [31:0] unique_identifier_half_o,
  output logic      [11:0] next_capability_pointer_o,
  output logic             config_locked_o,
  output logic      [3:0]  arb_entry_bits_o
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic word_hit(input logic [11:0] adr, input logic [11:0] ofs);
    word_hit = (adr[11:2] == ofs[11:2]);
  endfunction : word_hit

  function automatic logic [31:0] byte_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    byte_merge = res;
  endfunction : byte_merge

  // ----------------------------------------
  // State
  // ----------------------------------------
  vc_cap_pkg::cap_state_t st;
  vc_cap_pkg::cap_state_t next_st;

  logic        req;
  logic        hit_serial;
  logic        hit_header;
  logic        hit_cap_one;
  logic        hit_cap_two;
  logic        hit_lock;
  logic        mapped;
  logic [1:0]  entry_size;
  logic [31:0] read_word;
  logic [31:0] merged;

  assign req         = cyc_i & stb_i;
  assign hit_serial  = req & word_hit(adr_i, `OFS_SERIAL_HIGH);
  assign hit_header  = req & word_hit(adr_i, `OFS_VC_HEADER);
  assign hit_cap_one = req & word_hit(adr_i, `OFS_CHAN_CAP_ONE);
  assign hit_cap_two = req & word_hit(adr_i, `OFS_CHAN_CAP_TWO);
  assign hit_lock    = req & word_hit(adr_i, `OFS_LOCK_CTRL);
  assign mapped      = hit_serial | hit_header | hit_cap_one | hit_cap_two | hit_lock;

  // Role is a strap, so the table size follows it without software
  assign entry_size = st.upstream ? `ENTRY_SIZE_UPSTREAM : `ENTRY_SIZE_DOWNSTREAM;

  entry_size_decode u_entry_size_decode (
    .size_i (entry_size),
    .bits_o (arb_entry_bits_o)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb begin
    read_word = `READ_ZERO;
    if (hit_serial) begin
      read_word = st.serial_high;
    end else if (hit_header) begin
      read_word = {st.next_ptr, `CAP_VERSION_VALUE, `CAP_ID_VALUE};
    end else if (hit_cap_one) begin
      read_word = {20'h0_0000, entry_size, `ARB_TIME_REF, 1'b0, `LOW_PRI_CH_COUNT,
                   1'b0, `EXTRA_CH_COUNT};
    end else if (hit_cap_two) begin
      // Only one channel, so no arbitration scheme is offered
      read_word = {`CH_ARB_TABLE_OFS, 16'h0000, `CH_ARB_SUPPORT};
    end else if (hit_lock) begin
      read_word = {30'h0000_0000, st.upstream, st.locked};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  assign merged = byte_merge({st.next_ptr, 20'h0_0000}, dat_i, sel_i);

  always_comb begin
    next_st = st;
    case (st.phase)
      vc_cap_pkg::PHASE_IDLE: begin
        if (req) begin
          next_st.phase    = vc_cap_pkg::PHASE_ANSWER;
          next_st.unmapped = ~mapped;
          next_st.rdata    = read_word;
        end
      end
      vc_cap_pkg::PHASE_ANSWER: begin
        next_st.phase    = vc_cap_pkg::PHASE_IDLE;
        next_st.unmapped = 1'b0;
        // Writes land on the edge that the master sees ack
        if (req && we_i && !st.unmapped) begin
          if (hit_serial && !st.locked) begin
            next_st.serial_high = byte_merge(st.serial_high, dat_i, sel_i);
          end
          if (hit_header && !st.locked) begin
            next_st.next_ptr = merged[`NEXT_PTR_MSB:`NEXT_PTR_LSB];
          end
          if (hit_lock && sel_i[0] && dat_i[`LOCK_BIT]) begin
            next_st.locked = 1'b1;
          end
        end
      end
      default: begin
        next_st.phase = vc_cap_pkg::PHASE_IDLE;
      end
    endcase
    // Hot reset spares the sticky identifier word
    if (hot_reset_i) begin
      next_st.locked   = 1'b0;
      next_st.next_ptr = `NEXT_PTR_RESET;
    end
    if (rst_i) begin
      next_st.phase       = vc_cap_pkg::PHASE_IDLE;
      next_st.unmapped    = 1'b0;
      next_st.rdata       = `READ_ZERO;
      next_st.serial_high = `SERIAL_HIGH_RESET;
      next_st.next_ptr    = `NEXT_PTR_RESET;
      next_st.locked      = 1'b0;
      next_st.upstream    = upstream_port_i;
    end
  end

  always_ff @(posedge clk_i) begin
    st <= next_st;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign dat_o                     = st.rdata;
  assign ack_o                     = (st.phase == vc_cap_pkg::PHASE_ANSWER) & ~st.unmapped;
  assign err_o                     = (st.phase == vc_cap_pkg::PHASE_ANSWER) & st.unmapped;
  assign unique_identifier_half_o  = st.serial_high;
  assign next_capability_pointer_o = st.next_ptr;
  assign config_locked_o           = st.locked;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic rd_ans;
  assign rd_ans = ack_o & ~we_i;

  a_answer_one_cycle: assert property (
    (req && st.phase == vc_cap_pkg::PHASE_IDLE && !hot_reset_i)
      |=> (ack_o || err_o) ##1 !(ack_o || err_o))
    else $error("bus answer not a single cycle");

  a_serial_write_open: assert property (
    (ack_o && we_i && hit_serial && !st.locked && sel_i == 4'hF && !hot_reset_i)
      |=> unique_identifier_half_o == $past(dat_i))
    else $error("unlocked identifier write lost");

  a_serial_write_locked: assert property (
    (ack_o && we_i && hit_serial && st.locked) |=> $stable(unique_identifier_half_o))
    else $error("locked identifier word changed");

  a_header_identifier: assert property (
    (rd_ans && hit_header) |-> dat_o[`CAPABILITY_IDENTIFIER_MSB:`CAPABILITY_IDENTIFIER_LSB] == `CAP_ID_VALUE)
    else $error("capability identifier wrong");

  a_header_version: assert property (
    (rd_ans && hit_header) |-> dat_o[`CAPABILITY_VERSION_MSB:`CAPABILITY_VERSION_LSB] == `CAP_VERSION_VALUE)
    else $error("capability version wrong");

  a_next_ptr_lock: assert property (
    (ack_o && we_i && hit_header && !hot_reset_i)
      |=> next_capability_pointer_o == ($past(st.locked) ? $past(st.next_ptr)
                                       : $past(merged[`NEXT_PTR_MSB:`NEXT_PTR_LSB])))
    else $error("next pointer lock broken");

  a_next_ptr_read: assert property (
    (rd_ans && hit_header) |-> dat_o[`NEXT_PTR_MSB:`NEXT_PTR_LSB] == next_capability_pointer_o)
    else $error("next pointer read mismatch");

  a_extra_count: assert property (
    (rd_ans && hit_cap_one) |-> dat_o[`EXTRA_CNT_MSB:`EXTRA_CNT_LSB] == `EXTRA_CH_COUNT)
    else $error("extra channel count nonzero");

  a_low_pri_count: assert property (
    (rd_ans && hit_cap_one) |-> dat_o[`LOWPRI_CNT_MSB:`LOWPRI_CNT_LSB] == `LOW_PRI_CH_COUNT)
    else $error("low priority count nonzero");

  a_time_reference: assert property (
    (rd_ans && hit_cap_one) |-> dat_o[`TIME_REF_MSB:`TIME_REF_LSB] == `ARB_TIME_REF)
    else $error("time reference nonzero");

  a_entry_size_role: assert property (
    (rd_ans && hit_cap_one) |-> dat_o[`ENTRY_SIZE_MSB:`ENTRY_SIZE_LSB] ==
      (st.upstream ? `ENTRY_SIZE_UPSTREAM : `ENTRY_SIZE_DOWNSTREAM))
    else $error("entry size does not follow role");

  a_entry_bits_map: assert property (
    arb_entry_bits_o == (`ENTRY_BITS_1 << entry_size))
    else $error("entry width decode wrong");

  a_arb_support: assert property (
    (rd_ans && hit_cap_two) |-> dat_o[`ARB_SUP_MSB:`ARB_SUP_LSB] == `CH_ARB_SUPPORT)
    else $error("arbitration support nonzero");

  a_arb_reserved: assert property (
    (rd_ans && hit_cap_two) |-> dat_o[`ARB_SUP_MSB:`ARB_SUP_RSVD_LSB] == 4'h0)
    else $error("reserved support bits set");

  a_table_offset: assert property (
    (rd_ans && hit_cap_two) |-> dat_o[`TABLE_OFS_MSB:`TABLE_OFS_LSB] == `CH_ARB_TABLE_OFS)
    else $error("arbitration table offset nonzero");

  a_reserved_zero: assert property (
    (rd_ans && hit_cap_one) |-> (dat_o[`CAP1_RSVD_MSB:`CAP1_RSVD_LSB] == 20'h0_0000
      && !dat_o[`CAP1_RSVD_A] && !dat_o[`CAP1_RSVD_B]))
    else $error("reserved bits of capability one set");

  a_cap_two_reserved: assert property (
    (rd_ans && hit_cap_two) |-> dat_o[`CAP2_RSVD_MSB:`CAP2_RSVD_LSB] == 16'h0000)
    else $error("reserved bits of capability two set");

  a_readonly_write: assert property (
    (ack_o && we_i && (hit_cap_one || hit_cap_two))
      |=> $stable(unique_identifier_half_o) && $stable(config_locked_o))
    else $error("read-only write changed state");

endmodule : vc_capability_registers

// [verif/vc_capability_registers_tb_top.sv]
`timescale 1ns/1ns
`include "vc_cap_params.svh"

module vc_capability_registers_tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        hot_reset_i;
  logic        upstream_port_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  logic [31:0] unique_identifier_half_o;
  logic [11:0] next_capability_pointer_o;
  logic        config_locked_o;
  logic [3:0]  arb_entry_bits_o;
  int          err_total;
  int          checks_done;

  vc_capability_registers vc_capability_registers_inst (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .hot_reset_i               (hot_reset_i),
    .upstream_port_i           (upstream_port_i),
    .cyc_i                     (cyc_i),
    .stb_i                     (stb_i),
    .we_i                      (we_i),
    .adr_i                     (adr_i),
    .sel_i                     (sel_i),
    .dat_i                     (dat_i),
    .dat_o                     (dat_o),
    .ack_o                     (ack_o),
    .err_o                     (err_o),
    .unique_identifier_half_o  (unique_identifier_half_o),
    .next_capability_pointer_o (next_capability_pointer_o),
    .config_locked_o           (config_locked_o),
    .arb_entry_bits_o          (arb_entry_bits_o)
  );

  // ----------------------------------------
  // Clock, shared tasks
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("checks_done=%0d err_total=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
      err_total++;
    end
  endtask : chk

  // Values seen right after an edge are the ones sampled at it
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
    q = dat_o;
    e = err_o;
    if (n >= 20) chk(32'h0000_0000, 32'h0000_0001, "bus timeout");
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] q;
    logic        e;
    wb(1'b0, a, 32'h0000_0000, 4'hF, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0000, msg);
    chk(q, exp, msg);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    logic        e;
    wb(1'b1, a, d, s, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0000, "write refused");
  endtask : wr

  task automatic do_reset(input logic up);
    @(posedge clk_i);
    rst_i           <= 1'b1;
    upstream_port_i <= up;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    rd(`OFS_SERIAL_HIGH, 32'h0000_0000, "serial reset");
    rd(`OFS_VC_HEADER, 32'h0001_0002, "header reset");
    rd(`OFS_CHAN_CAP_ONE, 32'h0000_0000, "cap one down");
    rd(`OFS_CHAN_CAP_TWO, 32'h0000_0000, "cap two");
    chk({28'h000_0000, arb_entry_bits_o}, 32'h0000_0001, "entry bits down");
  endtask : t_reset_values

  task automatic t_writes;
    logic [31:0] q;
    logic        e;
    wr(`OFS_SERIAL_HIGH, 32'h1234_5678, 4'hF);
    wr(`OFS_SERIAL_HIGH, 32'hAABB_CCDD, 4'h5);
    rd(`OFS_SERIAL_HIGH, 32'h12BB_56DD, "serial byte merge");
    chk(unique_identifier_half_o, 32'h12BB_56DD, "serial out");
    wr(`OFS_VC_HEADER, 32'hFFFF_FFFF, 4'hF);
    rd(`OFS_VC_HEADER, 32'hFFF1_0002, "header ptr write");
    wr(`OFS_VC_HEADER, 32'hABCD_EF01, 4'h8);
    rd(`OFS_VC_HEADER, 32'hABF1_0002, "header ptr top byte");
    @(posedge clk_i);
    chk({20'h0_0000, next_capability_pointer_o}, 32'h0000_0ABF, "ptr out");
    wr(`OFS_CHAN_CAP_ONE, 32'hFFFF_FFFF, 4'hF);
    wr(`OFS_CHAN_CAP_TWO, 32'hFFFF_FFFF, 4'hF);
    rd(`OFS_CHAN_CAP_ONE, 32'h0000_0000, "cap one write");
    rd(`OFS_CHAN_CAP_TWO, 32'h0000_0000, "cap two write");
    wb(1'b0, 12'h20C, 32'h0000_0000, 4'hF, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped err");
    chk(q, 32'h0000_0000, "unmapped data");
    wb(1'b1, 12'h184, 32'hFFFF_FFFF, 4'hF, q, e);
    chk({31'h0000_0000, e}, 32'h0000_0001, "unmapped write err");
    rd(`OFS_SERIAL_HIGH, 32'h12BB_56DD, "serial after unmapped");
  endtask : t_writes

  task automatic t_lock;
    wr(`OFS_LOCK_CTRL, 32'h0000_0001, 4'hF);
    rd(`OFS_LOCK_CTRL, 32'h0000_0001, "lock readback");
    wr(`OFS_SERIAL_HIGH, 32'h0BAD_0BAD, 4'hF);
    wr(`OFS_VC_HEADER, 32'h0000_0000, 4'hF);
    rd(`OFS_SERIAL_HIGH, 32'h12BB_56DD, "serial locked");
    rd(`OFS_VC_HEADER, 32'hABF1_0002, "ptr locked");
    chk({31'h0000_0000, config_locked_o}, 32'h0000_0001, "lock out");
  endtask : t_lock

  // Sticky word must survive a hot reset, lock and pointer must not
  task automatic t_hot_reset;
    @(posedge clk_i);
    hot_reset_i <= 1'b1;
    @(posedge clk_i);
    hot_reset_i <= 1'b0;
    rd(`OFS_VC_HEADER, 32'h0001_0002, "ptr hot reset");
    rd(`OFS_SERIAL_HIGH, 32'h12BB_56DD, "serial sticky");
    chk({31'h0000_0000, config_locked_o}, 32'h0000_0000, "unlock");
    wr(`OFS_SERIAL_HIGH, 32'hCAFE_F00D, 4'hF);
    rd(`OFS_SERIAL_HIGH, 32'hCAFE_F00D, "serial unlocked");
  endtask : t_hot_reset

  task automatic t_upstream;
    do_reset(1'b1);
    rd(`OFS_SERIAL_HIGH, 32'h0000_0000, "serial cold reset");
    rd(`OFS_CHAN_CAP_ONE, 32'h0000_0800, "cap one up");
    chk({28'h000_0000, arb_entry_bits_o}, 32'h0000_0004, "entry bits up");
    rd(`OFS_LOCK_CTRL, 32'h0000_0002, "role bit");
    rd(`OFS_CHAN_CAP_TWO, 32'h0000_0000, "cap two up");
  endtask : t_upstream

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    err_total       = 0;
    checks_done     = 0;
    rst_i           = 1'b1;
    hot_reset_i     = 1'b0;
    upstream_port_i = 1'b0;
    cyc_i           = 1'b0;
    stb_i           = 1'b0;
    we_i            = 1'b0;
    adr_i           = 12'h000;
    sel_i           = 4'h0;
    dat_i           = 32'h0000_0000;
    // Reset is already high from time zero, so count five edges only
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_values();
    t_writes();
    t_lock();
    t_hot_reset();
    t_upstream();
    conclude();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    err_total++;
    conclude();
  end
endmodule : vc_capability_registers_tb_top
